/* File: hw/mps_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - sample transparency only after loop formed
// - level at or above threshold means transparency
// - type mismatch suspends print, raises indication
// - mismatched sheet still transferred, fused, ejected
// - after error hold unfed sheets, others finish
// - length timed per source start/stop events
// - lower trays get second clutch-based length check
// - no length check for duplex sheets
// - size mismatch suspends print, ejects sheet
// - size error held until power or reset command
// - size error in duplex becomes jam, halt
// - feed sensor must assert within feed timeout
// - feed clutch on at registration clutch: jam
// - lower feed sensor starts vertical conveyance checks
// - normal sheets: transfer section release/exit timeouts
// - exit release and duplex path arrival timeouts
// - duplex feed starts registration and release checks
// - jam suspends print, raises jam, scans leftovers
// - doors closed after opening clear jam, rescan
// - scan walks sensors, any asserted means jam
module mps_top
  import mps_pkg::*;
#(
  parameter int LONG_HOLD = LONG_HOLD_CYC
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        registration_sensor,
  input  wire logic        lower_feed_path_sensor,
  input  wire logic        exit_sensor,
  input  wire logic        duplex_path_sensor,
  input  wire logic        duplex_feed_sensor,
  input  wire logic        long_registration_sensor,
  input  wire logic        door_open,
  input  wire logic        first_feed_clutch,
  input  wire logic        second_feed_clutch,
  input  wire logic        lower_feed_clutch,
  input  wire logic        registration_clutch,
  input  wire logic        duplex_transport_motor,
  input  wire logic        loop_formed,
  input  wire logic [7:0]  transparency_level,
  output logic             print_suspend,
  output logic             hold_unfed_sheets,
  output logic             halt_all,
  output logic             type_mismatch_indication,
  output logic             size_mismatch_indication,
  output logic             jam_indication
);

  // pin synchronisers: sensors and door switch
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] sync_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_a <= '0;
      sync_b <= '0;
      sync_q <= '0;
    end
    else
    begin
      sync_a <= {door_open, long_registration_sensor, duplex_feed_sensor, duplex_path_sensor,
                 exit_sensor, lower_feed_path_sensor, registration_sensor};
      sync_b <= sync_a;
      sync_q <= sync_b;
    end
  end
  logic reg_s, low_s, exit_s, dpath_s, dfeed_s, long_s, door_s;
  assign {door_s, long_s, dfeed_s, dpath_s, exit_s, low_s, reg_s} = sync_b;
  logic reg_r, reg_f, low_r, low_f, exit_r, exit_f, dpath_r, dpath_f, dfeed_r;
  assign reg_r   = reg_s & ~sync_q[0];
  assign reg_f   = ~reg_s & sync_q[0];
  assign low_r   = low_s & ~sync_q[1];
  assign low_f   = ~low_s & sync_q[1];
  assign exit_r  = exit_s & ~sync_q[2];
  assign exit_f  = ~exit_s & sync_q[2];
  assign dpath_r = dpath_s & ~sync_q[3];
  assign dpath_f = ~dpath_s & sync_q[3];
  assign dfeed_r = dfeed_s & ~sync_q[4];

  // same-clock actuator edges
  logic [4:0] act_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      act_q <= '0;
    else
      act_q <= {loop_formed, duplex_transport_motor, registration_clutch,
                lower_feed_clutch, first_feed_clutch};
  end
  logic cl1_r, cll_r, rcl_r, mot_r, loop_r, cl2_r;
  assign cl1_r  = first_feed_clutch & ~act_q[0];
  assign cll_r  = lower_feed_clutch & ~act_q[1];
  assign rcl_r  = registration_clutch & ~act_q[2];
  assign mot_r  = duplex_transport_motor & ~act_q[3];
  assign loop_r = loop_formed & ~act_q[4];
  logic cl3_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cl3_q <= 1'b0;
    else
      cl3_q <= second_feed_clutch;
  end
  assign cl2_r = second_feed_clutch & ~cl3_q;

  // software settings
  logic [CTRL_W-1:0] ctrl;
  logic [7:0]        thresh;
  logic [31:0]       len_min, len_max, t_feed, t_vert, t_xfer, t_exit, t_dup, len_last;
  logic              type_err, size_err, jam, halt, door_seen;
  logic [3:0]        jam_code;
  logic [NSENS-1:0]  remain;
  mps_scan_e         scan_st;
  logic [1:0]        src;
  logic              side2, lower, long_sheet;
  assign src        = ctrl[CTRL_SRC_LO +: 2];
  assign side2      = ctrl[CTRL_SIDE2];
  assign long_sheet = ctrl[CTRL_LONG];
  assign lower      = (src == SRC_TRAY3) || (src == SRC_TRAY4);

  // ahb-lite slave, zero wait states
  logic       dp_wr;
  logic [7:0] dp_addr;
  logic       ap_take;
  assign ap_take   = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end
    else
    begin
      dp_wr   <= ap_take & hwrite;
      dp_addr <= haddr[7:0];
    end
  end
  logic [31:0] status;
  assign status = {8'h00, 3'h0, remain, 4'h0, jam_code, 3'h0,
                   (scan_st != SCAN_IDLE), halt, jam, size_err, type_err};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else if (ap_take & ~hwrite)
    begin
      // unmapped offsets read zero
      if (haddr[7:0] == OFS_CTRL)          hrdata <= {26'h0, ctrl};
      else if (haddr[7:0] == OFS_THRESH)   hrdata <= {24'h0, thresh};
      else if (haddr[7:0] == OFS_LEN_MIN)  hrdata <= len_min;
      else if (haddr[7:0] == OFS_LEN_MAX)  hrdata <= len_max;
      else if (haddr[7:0] == OFS_T_FEED)   hrdata <= t_feed;
      else if (haddr[7:0] == OFS_T_VERT)   hrdata <= t_vert;
      else if (haddr[7:0] == OFS_T_XFER)   hrdata <= t_xfer;
      else if (haddr[7:0] == OFS_T_EXIT)   hrdata <= t_exit;
      else if (haddr[7:0] == OFS_T_DUP)    hrdata <= t_dup;
      else if (haddr[7:0] == OFS_STATUS)   hrdata <= status;
      else if (haddr[7:0] == OFS_LEN_LAST) hrdata <= len_last;
      else                                 hrdata <= '0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl    <= '0;
      thresh  <= RST_THRESH;
      len_min <= RST_LEN_MIN;
      len_max <= RST_LEN_MAX;
      t_feed  <= RST_TIMEOUT;
      t_vert  <= RST_TIMEOUT;
      t_xfer  <= RST_TIMEOUT;
      t_exit  <= RST_TIMEOUT;
      t_dup   <= RST_TIMEOUT;
    end
    else if (dp_wr)
    begin
      if (dp_addr == OFS_CTRL)         ctrl    <= hwdata[CTRL_W-1:0];
      else if (dp_addr == OFS_THRESH)  thresh  <= hwdata[7:0];
      else if (dp_addr == OFS_LEN_MIN) len_min <= hwdata;
      else if (dp_addr == OFS_LEN_MAX) len_max <= hwdata;
      else if (dp_addr == OFS_T_FEED)  t_feed  <= hwdata;
      else if (dp_addr == OFS_T_VERT)  t_vert  <= hwdata;
      else if (dp_addr == OFS_T_XFER)  t_xfer  <= hwdata;
      else if (dp_addr == OFS_T_EXIT)  t_exit  <= hwdata;
      else if (dp_addr == OFS_T_DUP)   t_dup   <= hwdata;
    end
  end
  logic size_rst, type_rst;
  assign size_rst = dp_wr & (dp_addr == OFS_CMD) & hwdata[CMD_SIZE_RST];
  assign type_rst = dp_wr & (dp_addr == OFS_CMD) & hwdata[CMD_TYPE_RST];

  // media type check
  logic is_transp, type_hit;
  assign is_transp = (transparency_level >= thresh);
  assign type_hit  = loop_r & (is_transp != ctrl[CTRL_TRANSP]);

  // length measurement, two windows for lower trays
  logic [31:0] len_a, len_b;
  logic        run_a, run_b, stop_a, stop_b, start_a;
  assign start_a = side2 ? 1'b0 : (lower ? low_r : rcl_r);
  assign stop_a  = run_a & (lower ? low_f : reg_f);
  assign stop_b  = run_b & low_f;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_a <= 1'b0;
      run_b <= 1'b0;
      len_a <= '0;
      len_b <= '0;
    end
    else
    begin
      if (start_a)
      begin
        run_a <= 1'b1;
        len_a <= '0;
      end
      else if (stop_a)
        run_a <= 1'b0;
      else if (run_a)
        len_a <= len_a + 32'h1;
      if (~side2 & lower & rcl_r)
      begin
        run_b <= 1'b1;
        len_b <= '0;
      end
      else if (stop_b)
        run_b <= 1'b0;
      else if (run_b)
        len_b <= len_b + 32'h1;
    end
  end
  logic bad_a, bad_b, size_hit;
  assign bad_a    = stop_a & ((len_a < len_min) | (len_a > len_max));
  assign bad_b    = stop_b & ((len_b < len_min) | (len_b > len_max));
  assign size_hit = bad_a | bad_b;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      len_last <= '0;
    else if (stop_b)
      len_last <= len_b;
    else if (stop_a)
      len_last <= len_a;
  end

  // misfeed watch timers
  logic [NW-1:0] w_start, w_done, w_arm, w_to;
  logic [31:0]   w_lim [NW];
  logic [31:0]   w_cnt [NW];
  logic feed_start, feed_done;
  always_comb
  begin
    feed_start = 1'b0;
    feed_done  = reg_r;
    if (side2)
      feed_start = mot_r;
    else if (src == SRC_TRAY1)
      feed_start = cl1_r;
    else if (src == SRC_TRAY2)
      feed_start = cl2_r;
    else
    begin
      feed_start = cll_r;
      feed_done  = low_r;
    end
  end
  assign w_start[0]  = feed_start;
  assign w_done[0]   = feed_done;
  assign w_lim[0]    = t_feed;
  assign w_start[1]  = lower & low_r;
  assign w_done[1]   = reg_r;
  assign w_lim[1]    = t_vert;
  assign w_start[2]  = lower & low_r;
  assign w_done[2]   = low_f;
  assign w_lim[2]    = t_vert;
  assign w_start[3]  = ~long_sheet & reg_r;
  assign w_done[3]   = reg_f;
  assign w_lim[3]    = t_xfer;
  assign w_start[4]  = ~long_sheet & reg_r;
  assign w_done[4]   = exit_r;
  assign w_lim[4]    = t_xfer;
  assign w_start[5]  = ~long_sheet & rcl_r;
  assign w_done[5]   = reg_f;
  assign w_lim[5]    = t_xfer;
  assign w_start[6]  = exit_r;
  assign w_done[6]   = exit_f;
  assign w_lim[6]    = t_exit;
  assign w_start[7]  = ctrl[CTRL_DUPLEX] & ~side2 & exit_f;
  assign w_done[7]   = dpath_r;
  assign w_lim[7]    = t_exit;
  assign w_start[8]  = dfeed_r;
  assign w_done[8]   = reg_r;
  assign w_lim[8]    = t_dup;
  assign w_start[9]  = dfeed_r;
  assign w_done[9]   = dpath_f;
  assign w_lim[9]    = t_dup;
  assign w_start[10] = long_sheet & reg_r;
  assign w_done[10]  = ~reg_s & ~long_s;
  assign w_lim[10]   = 32'(LONG_HOLD);

  for (genvar i = 0; i < NW; i++)
  begin : g_watch
    assign w_to[i] = w_arm[i] & ~w_done[i] & (w_cnt[i] >= w_lim[i]);
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        w_arm[i] <= 1'b0;
        w_cnt[i] <= '0;
      end
      else if (w_start[i] & ~halt)
      begin
        w_arm[i] <= 1'b1;
        w_cnt[i] <= 32'h1;
      end
      else if (w_done[i] | w_to[i] | halt)
        w_arm[i] <= 1'b0;
      else if (w_arm[i])
        w_cnt[i] <= w_cnt[i] + 32'h1;
    end
  end

  // jam sources; size error while duplexing counts as a jam
  logic ovlp, jam_hit, size_jam;
  assign ovlp     = rcl_r & (first_feed_clutch | second_feed_clutch | lower_feed_clutch);
  assign size_jam = size_hit & ctrl[CTRL_DUPLEX];
  assign jam_hit  = (|w_to) | ovlp | size_jam;

  // doors: clear only on the close that follows an opening
  logic door_clear;
  assign door_clear = door_seen & ~door_s;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      door_seen <= 1'b0;
    else if (door_s)
      door_seen <= 1'b1;
    else
      door_seen <= 1'b0;
  end

  // leftover scan; starts after reset, after a jam, after doors closed
  logic [2:0] scan_idx;
  logic       scan_go, scan_hit;
  assign scan_go  = jam_hit | door_clear;
  assign scan_hit = (scan_st == SCAN_WALK) & sync_b[scan_idx];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scan_st  <= SCAN_WALK;
      scan_idx <= '0;
    end
    else
    begin
      case (scan_st)
        SCAN_IDLE:
        begin
          if (scan_go)
          begin
            scan_st  <= SCAN_WALK;
            scan_idx <= '0;
          end
        end
        SCAN_WALK:
        begin
          if (scan_idx == 3'(NSENS - 1))
            scan_st <= SCAN_DONE;
          else
            scan_idx <= scan_idx + 3'h1;
        end
        SCAN_DONE:
        begin
          // a request landing here must not be lost
          if (scan_go)
          begin
            scan_st  <= SCAN_WALK;
            scan_idx <= '0;
          end
          else
            scan_st <= SCAN_IDLE;
        end
        default:
          scan_st <= SCAN_IDLE;
      endcase
    end
  end

  // sticky flags: a set in the clear cycle wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      type_err <= 1'b0;
      size_err <= 1'b0;
      jam      <= 1'b0;
      halt     <= 1'b0;
      jam_code <= '0;
      remain   <= '0;
    end
    else
    begin
      if (type_hit)
        type_err <= 1'b1;
      else if (type_rst)
        type_err <= 1'b0;
      if (size_hit & ~ctrl[CTRL_DUPLEX])
        size_err <= 1'b1;
      else if (size_rst)
        size_err <= 1'b0;
      if (jam_hit | scan_hit)
        jam <= 1'b1;
      else if (door_clear)
        jam <= 1'b0;
      if (jam_hit)
        halt <= 1'b1;
      else if (door_clear)
        halt <= 1'b0;
      if (jam_hit & (~jam | door_clear))
      begin
        jam_code <= 4'(CODE_OVLP);
        for (int k = NW - 1; k >= 0; k--)
          if (w_to[k])
            jam_code <= 4'(k);
      end
      else if (door_clear)
        jam_code <= '0;
      // a sensor found in the clear cycle still counts
      if (door_clear)
        remain <= '0;
      if (scan_hit)
        remain[scan_idx] <= 1'b1;
    end
  end

  // type/size errors stop new sheets only; the sheet in the path is carried
  // through transfer, fusing and exit since transport is not stopped
  assign print_suspend            = type_err | size_err | jam;
  assign hold_unfed_sheets        = type_err | size_err | jam;
  assign halt_all                 = halt;
  assign type_mismatch_indication = type_err;
  assign size_mismatch_indication = size_err;
  assign jam_indication           = jam;

  // checks
  a_type_raise: assert property (@(posedge hclk) disable iff (!hresetn)
    type_hit |=> type_err && print_suspend) else $error("type mismatch not raised");
  a_type_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !type_err ##1 type_err |-> $past(loop_r)) else $error("type set without loop");
  a_size_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    size_err && !size_rst |=> size_err) else $error("size error dropped");
  a_size_dup_jam: assert property (@(posedge hclk) disable iff (!hresetn)
    size_hit && ctrl[CTRL_DUPLEX] |=> halt && jam && !size_err) else $error("duplex size");
  a_no_len_dup: assert property (@(posedge hclk) disable iff (!hresetn)
    side2 && !run_a && !run_b |=> !run_a && !run_b) else $error("duplex sheet measured");
  a_ovlp_jam: assert property (@(posedge hclk) disable iff (!hresetn)
    ovlp |=> jam && halt) else $error("clutch overlap missed");
  a_feed_timeout: assert property (@(posedge hclk) disable iff (!hresetn)
    w_to[0] |=> jam ##0 print_suspend) else $error("feed timeout missed");
  a_jam_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    jam && !door_clear |=> jam) else $error("jam dropped without doors");
  a_scan_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(scan_st == SCAN_WALK) |-> ##[1:6] scan_st == SCAN_DONE) else $error("scan stuck");
  a_door_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    door_clear && !jam_hit |=> !halt ##1 scan_st == SCAN_WALK) else $error("doors no rescan");
  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp) else $error("bus not ready");
  c_type_err: cover property (@(posedge hclk) disable iff (!hresetn) type_hit);
  c_size_err: cover property (@(posedge hclk) disable iff (!hresetn) bad_b && !bad_a);
  c_long_jam: cover property (@(posedge hclk) disable iff (!hresetn) w_to[10]);
  c_rescan: cover property (@(posedge hclk) disable iff (!hresetn) door_clear ##[1:8] scan_hit);

endmodule : mps_top

/* File: inc/mps_pkg.sv */
package mps_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_THRESH   = 8'h04;
  localparam logic [7:0] OFS_LEN_MIN  = 8'h08;
  localparam logic [7:0] OFS_LEN_MAX  = 8'h0C;
  localparam logic [7:0] OFS_T_FEED   = 8'h10;
  localparam logic [7:0] OFS_T_VERT   = 8'h14;
  localparam logic [7:0] OFS_T_XFER   = 8'h18;
  localparam logic [7:0] OFS_T_EXIT   = 8'h1C;
  localparam logic [7:0] OFS_T_DUP    = 8'h20;
  localparam logic [7:0] OFS_STATUS   = 8'h24;
  localparam logic [7:0] OFS_CMD      = 8'h28;
  localparam logic [7:0] OFS_LEN_LAST = 8'h2C;
  // ctrl fields
  localparam int CTRL_TRANSP  = 0;
  localparam int CTRL_DUPLEX  = 1;
  localparam int CTRL_SRC_LO  = 2;
  localparam int CTRL_SIDE2   = 4;
  localparam int CTRL_LONG    = 5;
  localparam int CTRL_W       = 6;
  // cmd fields
  localparam int CMD_SIZE_RST = 0;
  localparam int CMD_TYPE_RST = 1;
  // status fields
  localparam int ST_TYPE      = 0;
  localparam int ST_SIZE      = 1;
  localparam int ST_JAM       = 2;
  localparam int ST_HALT      = 3;
  localparam int ST_SCAN      = 4;
  localparam int ST_CODE_LO   = 8;
  localparam int ST_REM_LO    = 16;
  // sources
  localparam logic [1:0] SRC_TRAY1 = 2'h0;
  localparam logic [1:0] SRC_TRAY2 = 2'h1;
  localparam logic [1:0] SRC_TRAY3 = 2'h2;
  localparam logic [1:0] SRC_TRAY4 = 2'h3;
  // reset values
  localparam logic [31:0] RST_TIMEOUT = 32'h000F_4240;
  localparam logic [7:0]  RST_THRESH  = 8'h80;
  localparam logic [31:0] RST_LEN_MIN = 32'h0000_0000;
  localparam logic [31:0] RST_LEN_MAX = 32'hFFFF_FFFF;
  // long-sheet hold time
  localparam int CLK_PERIOD_NS = 4;
  localparam longint LONG_HOLD_NS = 2000000000;
  localparam int LONG_HOLD_CYC = int'(LONG_HOLD_NS / CLK_PERIOD_NS);
  // sensors walked by the leftover scan
  localparam int NSENS = 5;
  // watch timers and jam codes
  localparam int NW        = 11;
  localparam int CODE_OVLP = 11;
  typedef enum logic [1:0]
  {
    SCAN_IDLE = 2'b00,
    SCAN_WALK = 2'b01,
    SCAN_DONE = 2'b10
  } mps_scan_e;
endpackage : mps_pkg

/* File: bench/mps_path.sv */
`timescale 1ns/1ps
// far side of the supervisor: path sensors, clutches, duplex motor, doors
module mps_path
(
  input  wire logic hclk,
  output logic       registration_sensor,
  output logic       lower_feed_path_sensor,
  output logic       exit_sensor,
  output logic       duplex_path_sensor,
  output logic       duplex_feed_sensor,
  output logic       long_registration_sensor,
  output logic       door_open,
  output logic       first_feed_clutch,
  output logic       second_feed_clutch,
  output logic       lower_feed_clutch,
  output logic       registration_clutch,
  output logic       duplex_transport_motor,
  output logic       loop_formed,
  output logic [7:0] transparency_level
);
  initial
  begin
    {registration_sensor, lower_feed_path_sensor, exit_sensor, duplex_path_sensor} = 4'h0;
    {duplex_feed_sensor, long_registration_sensor, door_open, first_feed_clutch} = 4'h0;
    {second_feed_clutch, lower_feed_clutch, registration_clutch} = 3'h0;
    {duplex_transport_motor, loop_formed} = 2'h0;
    transparency_level = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  // one tray 1 sheet; level before the loop is the opposite reading
  task automatic sheet(input logic [7:0] lvl, input int len);
    transparency_level <= ~lvl;
    first_feed_clutch <= 1'b1;
    tick(3);
    registration_sensor <= 1'b1;
    tick(2);
    first_feed_clutch <= 1'b0;
    tick(3);
    transparency_level <= lvl;
    loop_formed <= 1'b1;
    tick(3);
    registration_clutch <= 1'b1;
    tick(len);
    registration_sensor <= 1'b0;
    tick(3);
    exit_sensor <= 1'b1;
    registration_clutch <= 1'b0;
    loop_formed <= 1'b0;
    tick(4);
    exit_sensor <= 1'b0;
    tick(6);
  endtask : sheet

  // tray 2 clutch left on when the registration clutch engages
  task automatic overlap();
    second_feed_clutch <= 1'b1;
    registration_sensor <= 1'b1;
    tick(4);
    registration_clutch <= 1'b1;
    tick(1);
  endtask : overlap

  task automatic stuck(input logic feed, input logic ex);
    first_feed_clutch <= feed;
    exit_sensor <= ex;
    tick(1);
  endtask : stuck

  task automatic clear();
    {registration_sensor, exit_sensor, first_feed_clutch} <= 3'h0;
    {second_feed_clutch, registration_clutch} <= 2'h0;
    tick(1);
  endtask : clear

  // tray 3 sheet up the vertical path only
  task automatic lower(input int len);
    lower_feed_clutch <= 1'b1;
    tick(3);
    lower_feed_path_sensor <= 1'b1;
    lower_feed_clutch <= 1'b0;
    tick(len);
    lower_feed_path_sensor <= 1'b0;
    tick(6);
  endtask : lower

  task automatic door();
    door_open <= 1'b1;
    tick(4);
    door_open <= 1'b0;
    tick(1);
  endtask : door
endmodule : mps_path

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench
  import mps_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, d;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, print_suspend, hold_unfed_sheets, halt_all;
  logic type_mismatch_indication, size_mismatch_indication, jam_indication;
  logic registration_sensor, lower_feed_path_sensor, exit_sensor, duplex_path_sensor;
  logic duplex_feed_sensor, long_registration_sensor, door_open, first_feed_clutch;
  logic second_feed_clutch, lower_feed_clutch, registration_clutch;
  logic duplex_transport_motor, loop_formed;
  logic [7:0] transparency_level;
  int mismatches = 0;
  int checks_done = 0;

  always #2 hclk = ~hclk;

  mps_top #(.LONG_HOLD(50)) i_dut (.hready(hreadyout), .*);
  mps_path i_path (.*);

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : xfer

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(d, exp);
    chk(hresp, 32'h0);
  endtask : rd_chk

  // bounded wait; the flag must rise within lim cycles
  task automatic wait_jam(input int lim);
    int n;
    n = 0;
    while (jam_indication !== 1'b1 && n < lim)
    begin
      tick(1);
      n++;
    end
    chk(jam_indication, 32'h1);
  endtask : wait_jam

  task automatic t_regs();
    tick(10);
    rd_chk(OFS_STATUS, 32'h0);
    rd_chk(OFS_THRESH, {24'h0, RST_THRESH});
    rd_chk(OFS_LEN_MAX, RST_LEN_MAX);
    rd_chk(OFS_T_FEED, RST_TIMEOUT);
    rd_chk(8'h40, 32'h0);
    xfer(OFS_T_XFER, 1'b1, 32'h0000_1234);
    rd_chk(OFS_T_XFER, 32'h0000_1234);
  endtask : t_regs

  // threshold boundary against both media settings
  task automatic t_type();
    logic [8:0] tbl [4];
    logic err;
    tbl = '{9'h180, 9'h17F, 9'h080, 9'h07F};
    for (int i = 0; i < 4; i++)
    begin
      err = tbl[i][8] != (tbl[i][7:0] >= RST_THRESH);
      xfer(OFS_CTRL, 1'b1, {31'h0, tbl[i][8]});
      i_path.sheet(tbl[i][7:0], 10);
      chk(type_mismatch_indication, err);
      chk(print_suspend, err);
      chk(hold_unfed_sheets, err);
      chk(jam_indication, 32'h0);
      chk(halt_all, 32'h0);
      xfer(OFS_CMD, 1'b1, 32'h2);
      tick(2);
      chk(type_mismatch_indication, 32'h0);
    end
  endtask : t_type

  task automatic t_size();
    logic [31:0] mx [2];
    mx = '{32'd20, 32'd100};
    xfer(OFS_CTRL, 1'b1, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      xfer(OFS_LEN_MAX, 1'b1, mx[i]);
      i_path.sheet(8'h10, 40);
      xfer(OFS_LEN_LAST, 1'b0, 32'h0);
      chk(d >= 38 && d <= 44, 32'h1);
      tick(30);
      chk(size_mismatch_indication, i == 0);
      chk(jam_indication, 32'h0);
      xfer(OFS_CMD, 1'b1, 32'h1);
      tick(2);
      chk(size_mismatch_indication, 32'h0);
    end
  endtask : t_size

  task automatic t_feed();
    xfer(OFS_T_FEED, 1'b1, 32'd30);
    i_path.stuck(1'b1, 1'b0);
    tick(25);
    chk(jam_indication, 32'h0);
    wait_jam(12);
    chk(halt_all, 32'h1);
    chk(print_suspend, 32'h1);
    xfer(OFS_STATUS, 1'b0, 32'h0);
    chk(d[11:8], 32'h0);
    i_path.clear();
    i_path.door();
    tick(12);
    chk(jam_indication, 32'h0);
    chk(halt_all, 32'h0);
    xfer(OFS_T_FEED, 1'b1, RST_TIMEOUT);
  endtask : t_feed

  task automatic t_overlap_scan();
    i_path.overlap();
    wait_jam(8);
    xfer(OFS_STATUS, 1'b0, 32'h0);
    chk(d[11:8], CODE_OVLP);
    i_path.clear();
    i_path.stuck(1'b0, 1'b1);
    i_path.door();
    tick(3);
    chk(jam_indication, 32'h0);
    wait_jam(20);
    xfer(OFS_STATUS, 1'b0, 32'h0);
    chk(d[ST_REM_LO + 2], 32'h1);
    i_path.clear();
    i_path.door();
    tick(12);
    chk(jam_indication, 32'h0);
  endtask : t_overlap_scan

  // lower tray sheet too long while duplexing turns into a jam
  task automatic t_dup_size();
    xfer(OFS_CTRL, 1'b1, 32'h0000_000A);
    xfer(OFS_LEN_MAX, 1'b1, 32'd20);
    i_path.lower(40);
    wait_jam(8);
    chk(halt_all, 32'h1);
    chk(size_mismatch_indication, 32'h0);
    xfer(OFS_STATUS, 1'b0, 32'h0);
    chk(d[11:8], CODE_OVLP);
    i_path.door();
    tick(12);
    chk(jam_indication, 32'h0);
  endtask : t_dup_size

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_type();
    t_size();
    t_feed();
    t_overlap_scan();
    t_dup_size();
    wrap_up();
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    #40000;
    mismatches++;
    wrap_up();
  end
endmodule : testbench
